// File: bench/testbench.sv
// self-checking bench for the watchdog and reset-control top
// assumes one-cycle reset pulses; bus requests wait for waitrequest low
`timescale 1ns/10ps
module testbench;
   import wdrc_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic low_speed_osc_i = 1'b0;
   logic low_supply_i = 1'b0;
   logic watchdog_clear_instr_i = 1'b0;
   logic halt_instr_i = 1'b0;
   logic low_power_mode_i = 1'b0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, device_reset_o, pc_sp_clear_o, port_preset_o;
   logic timeout_status_flag_o, powerdown_flag_o;
   logic [31:0] rd_q[$];
   logic [1:0] ev_q[$];
   logic [7:0] lfsr = 8'h50;
   logic [7:0] r;
   logic armed = 1'b0;
   int miscompares = 0;
   int n_compared = 0;

   wdrc_top #(.SOFT_DLY_CYC(4), .QUAL_CYC(8)) i_wdrc_top (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .low_speed_osc_i(low_speed_osc_i), .low_supply_i(low_supply_i),
      .watchdog_clear_instr_i(watchdog_clear_instr_i), .halt_instr_i(halt_instr_i),
      .low_power_mode_i(low_power_mode_i), .device_reset_o(device_reset_o),
      .pc_sp_clear_o(pc_sp_clear_o), .port_preset_o(port_preset_o),
      .timeout_status_flag_o(timeout_status_flag_o), .powerdown_flag_o(powerdown_flag_o));

   initial begin
      forever #2.5 clock_i = ~clock_i;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_event(input logic [1:0] e, input logic [1:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value reset pulses expected %b seen %b", e, g);
      end
   endtask

   // sampled mid-cycle so the combinational waitrequest has settled
   always @(negedge clock_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0)
         chk_word("readdata", rd_q.size() ? rd_q.pop_front() : 32'hx, avs_readdata_o);
      if (armed && (device_reset_o !== 1'b0 || pc_sp_clear_o !== 1'b0))
         chk_event(ev_q.size() ? ev_q.pop_front() : 2'b00, {device_reset_o, pc_sp_clear_o});
   end

   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [31:0] e);
      lfsr = lfsr_next(lfsr);
      if (!w)
         rd_q.push_back(e);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_read_i <= !w;
      avs_write_i <= w;
      avs_writedata_i <= {lfsr, ~lfsr, lfsr, d};
      // waitrequest is taken at each rising edge while the request still stands
      do
         @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0);
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clock_i);
         low_speed_osc_i <= 1'b1;
         repeat (4) @(posedge clock_i);
         low_speed_osc_i <= 1'b0;
         repeat (3) @(posedge clock_i);
      end
   endtask

   task automatic instr(input logic h);
      @(posedge clock_i);
      halt_instr_i <= h;
      watchdog_clear_instr_i <= !h;
      @(posedge clock_i);
      halt_instr_i <= 1'b0;
      watchdog_clear_instr_i <= 1'b0;
   endtask

   task automatic end_of_test;
      if (rd_q.size() || ev_q.size())
         miscompares++;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      miscompares++;
      end_of_test;
   end

   initial begin
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      armed = 1'b1;
      bus(1'b0, WDRC_OFS_WDT_CTRL, 8'h0, {24'h0, WDRC_WDT_CTRL_RST});
      bus(1'b0, WDRC_OFS_RST_FLAGS, 8'h0, 32'h0);
      bus(1'b0, WDRC_OFS_STATUS, 8'h0, 32'h0);
      bus(1'b0, 4'h1, 8'h0, 32'h0);
      r = lfsr_next(8'h3c ^ lfsr);
      bus(1'b1, WDRC_OFS_RST_FLAGS, r, 32'h0);
      bus(1'b0, WDRC_OFS_RST_FLAGS, 8'h0, {24'h0, r & 8'h05});
      bus(1'b1, WDRC_OFS_RST_FLAGS, 8'h0, 32'h0);
      bus(1'b1, WDRC_OFS_FLASH_CTRL_ONE, 8'h54, 32'h0);
      ev_q.push_back(2'b10);
      bus(1'b1, WDRC_OFS_FLASH_CTRL_ONE, WDRC_FLASH_RESET_VAL, 32'h0);
      $display("test registers and flash reset done");
      bus(1'b1, WDRC_OFS_WDT_CTRL, {WDRC_KEY_B, 3'h1}, 32'h0);
      instr(1'b0);
      ticks(200);
      instr(1'b0);
      ticks(200);
      bus(1'b1, WDRC_OFS_WDT_CTRL, {WDRC_KEY_B, 3'h0}, 32'h0);
      ticks(50);
      ev_q.push_back(2'b10);
      ticks(10);
      bus(1'b0, WDRC_OFS_STATUS, 8'h0, 32'h1);
      bus(1'b0, WDRC_OFS_WDT_CTRL, 8'h0, {24'h0, WDRC_WDT_CTRL_RST});
      $display("test normal overflow done");
      bus(1'b1, WDRC_OFS_WDT_CTRL, {WDRC_KEY_B, 3'h0}, 32'h0);
      low_power_mode_i <= 1'b1;
      instr(1'b1);
      bus(1'b0, WDRC_OFS_STATUS, 8'h0, 32'h2);
      low_supply_i <= 1'b1;
      ticks(20);
      low_supply_i <= 1'b0;
      ticks(220);
      ev_q.push_back(2'b01);
      ticks(20);
      bus(1'b0, WDRC_OFS_STATUS, 8'h0, 32'h3);
      low_power_mode_i <= 1'b0;
      instr(1'b0);
      bus(1'b0, WDRC_OFS_STATUS, 8'h0, 32'h1);
      $display("test low power overflow done");
      low_supply_i <= 1'b1;
      ticks(5);
      low_supply_i <= 1'b0;
      ticks(5);
      low_supply_i <= 1'b1;
      ev_q.push_back(2'b10);
      ticks(12);
      low_supply_i <= 1'b0;
      bus(1'b0, WDRC_OFS_RST_FLAGS, 8'h0, 32'h4);
      bus(1'b0, WDRC_OFS_STATUS, 8'h0, 32'h1);
      $display("test brownout done");
      avs_byteenable_i <= {lfsr[3:1], 1'b0};
      bus(1'b1, WDRC_OFS_WDT_CTRL, 8'h0, 32'h0);
      avs_byteenable_i <= {lfsr[2:0], 1'b1};
      ev_q.push_back(2'b10);
      bus(1'b1, WDRC_OFS_WDT_CTRL, 8'h0, 32'h0);
      // long enough that a second, chained key reset would show as an extra pulse
      ticks(12);
      bus(1'b0, WDRC_OFS_RST_FLAGS, 8'h0, 32'h5);
      bus(1'b0, WDRC_OFS_WDT_CTRL, 8'h0, {24'h0, WDRC_WDT_CTRL_RST});
      bus(1'b1, WDRC_OFS_RST_FLAGS, 8'h0, 32'h0);
      bus(1'b0, WDRC_OFS_RST_FLAGS, 8'h0, 32'h0);
      $display("test bad key reset done");
      repeat (4) @(posedge clock_i);
      end_of_test;
   end
endmodule

// File: bench/wdrc_top_sva.sv
// timing checks on the ports of the watchdog and reset-control top
// assumes one clock domain and the two-cycle bus answer of the top
`timescale 1ns/10ps
module wdrc_top_sva
   import wdrc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic low_speed_osc_i,
   input wire logic low_supply_i,
   input wire logic watchdog_clear_instr_i,
   input wire logic halt_instr_i,
   input wire logic low_power_mode_i,
   input wire logic device_reset_o,
   input wire logic pc_sp_clear_o,
   input wire logic port_preset_o,
   input wire logic timeout_status_flag_o,
   input wire logic powerdown_flag_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd(logic [3:0] a);
      avs_read_i && !avs_waitrequest_o && avs_address_i == a;
   endsequence
   sequence s_flash_wr;
      avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
         && avs_address_i == WDRC_OFS_FLASH_CTRL_ONE
         && avs_writedata_i[7:0] == WDRC_FLASH_RESET_VAL;
   endsequence
   sequence s_preset;
      port_preset_o && pc_sp_clear_o ##1 !port_preset_o;
   endsequence
   flash_reset_a: assert property (s_flash_wr |=> device_reset_o)
      else $error("flash key write gave no reset");
   pulse_single_a: assert property (device_reset_o |=> !device_reset_o)
      else $error("device reset longer than one cycle");
   halt_pd_a: assert property (halt_instr_i |=> powerdown_flag_o)
      else $error("halt did not set power-down flag");
   clear_pd_a: assert property (watchdog_clear_instr_i && !halt_instr_i
      |=> !powerdown_flag_o)
      else $error("watchdog clear left power-down flag");
   lowpow_quiet_a: assert property (low_power_mode_i [*3] |-> !device_reset_o)
      else $error("full reset while in low power");
   pcsp_timeout_a: assert property ($rose(pc_sp_clear_o) |=> !pc_sp_clear_o && timeout_status_flag_o)
      else $error("bad pc and stack clear pulse");
   release_preset_a: assert property ($rose(rst_n_i) |-> s_preset)
      else $error("preset not held to release");
   flags_zero_a: assert property (s_rd(WDRC_OFS_RST_FLAGS) |->
      avs_readdata_o[31:3] == 29'h0 && !avs_readdata_o[1])
      else $error("unused flag bits not zero");
   // read data is captured in the wait cycle, so it shows the flags of that cycle
   status_read_a: assert property (s_rd(WDRC_OFS_STATUS) |->
      avs_readdata_o[1:0] == $past({powerdown_flag_o, timeout_status_flag_o}))
      else $error("status read differs from flags");
endmodule

bind wdrc_top wdrc_top_sva i_wdrc_top_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .low_speed_osc_i(low_speed_osc_i), .low_supply_i(low_supply_i),
   .watchdog_clear_instr_i(watchdog_clear_instr_i), .halt_instr_i(halt_instr_i),
   .low_power_mode_i(low_power_mode_i), .device_reset_o(device_reset_o),
   .pc_sp_clear_o(pc_sp_clear_o), .port_preset_o(port_preset_o),
   .timeout_status_flag_o(timeout_status_flag_o), .powerdown_flag_o(powerdown_flag_o));

// File: common/wdrc_if.sv
// carrier between the reset-control top and its counter and qualifier
// all signals are on clock_i
`timescale 1ns/10ps
interface wdrc_if;
   logic tick;
   logic clear;
   logic [2:0] sel;
   logic overflow;
   logic low_power;
   logic brownout_hit;
   modport top (input tick, input overflow, input brownout_hit,
                output clear, output sel, output low_power);
   modport ctr (output tick, output overflow, input clear, input sel);
   modport qual (input tick, input low_power, output brownout_hit);
endinterface

// File: common/wdrc_pkg.sv
// constants shared by the watchdog and reset-control block
// assumes a 32-bit avalon-mm slave with byte addressing
package wdrc_pkg;
   localparam int unsigned WDRC_CNT_W = 18;
   localparam int unsigned WDRC_DLY_W = 8;
   localparam logic [3:0] WDRC_OFS_WDT_CTRL = 4'h0;
   localparam logic [3:0] WDRC_OFS_RST_FLAGS = 4'h4;
   localparam logic [3:0] WDRC_OFS_STATUS = 4'h8;
   localparam logic [3:0] WDRC_OFS_FLASH_CTRL_ONE = 4'hc;
   localparam logic [7:0] WDRC_WDT_CTRL_RST = 8'h53;
   localparam logic [4:0] WDRC_KEY_A = 5'h0a;
   localparam logic [4:0] WDRC_KEY_B = 5'h15;
   localparam logic [7:0] WDRC_FLASH_RESET_VAL = 8'h55;
   localparam int unsigned WDRC_SOFT_FLAG_BIT = 0;
   localparam int unsigned WDRC_BROWNOUT_FLAG_BIT = 2;
   localparam int unsigned WDRC_TO_BIT = 0;
   localparam int unsigned WDRC_PDF_BIT = 1;
   localparam logic WDRC_BROWNOUT_FLAG_RST = 1'b0;
   localparam int unsigned WDRC_SOFT_DLY_CYC = 4;
   localparam int unsigned WDRC_BROWNOUT_QUAL_CYC = 8;
   localparam int unsigned WDRC_OSC_KHZ = 32;

   typedef enum logic [1:0] {WDRC_ST_RUN, WDRC_ST_DELAY} wdrc_state_t;

   // overflow exponent for each timeout_select code
   function automatic logic [4:0] wdrc_exp(input logic [2:0] sel);
      case (sel)
         3'h0: wdrc_exp = 5'h08;
         3'h1: wdrc_exp = 5'h0a;
         3'h2: wdrc_exp = 5'h0c;
         3'h3: wdrc_exp = 5'h0e;
         3'h4: wdrc_exp = 5'h0f;
         3'h5: wdrc_exp = 5'h10;
         3'h6: wdrc_exp = 5'h11;
         default: wdrc_exp = 5'h12;
      endcase
   endfunction

   function automatic logic wdrc_key_ok(input logic [4:0] key);
      wdrc_key_ok = (key == WDRC_KEY_A) || (key == WDRC_KEY_B);
   endfunction
endpackage

// File: design/wdrc_counter.sv
// watchdog counter advanced by edges of the low-speed oscillator
// assumes the oscillator pin is asynchronous to clock_i and much slower
`timescale 1ns/10ps
module wdrc_counter
   import wdrc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic low_speed_osc_i,
   wdrc_if.ctr bus
);
   logic [2:0] osc_q, osc_d;
   logic [WDRC_CNT_W-1:0] cnt_q, cnt_d;
   logic [WDRC_CNT_W-1:0] limit;
   logic tick;

   // only the oscillator advances the count, never the system clock
   assign tick = osc_q[1] & ~osc_q[2];
   // limit compared live, so a select change keeps the running count
   assign limit = WDRC_CNT_W'((19'h1 << wdrc_exp(bus.sel)) - 19'h1);

   always_comb begin
      osc_d = {osc_q[1:0], low_speed_osc_i};
      cnt_d = cnt_q;
      if (bus.clear) begin
         cnt_d = '0;
      end else if (tick) begin
         cnt_d = (cnt_q >= limit) ? '0 : cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_q <= 3'h0;
         cnt_q <= '0;
      end else begin
         osc_q <= osc_d;
         cnt_q <= cnt_d;
      end
   end

   assign bus.tick = tick;
   assign bus.overflow = tick & ~bus.clear & (cnt_q >= limit);
endmodule

// File: design/wdrc_qual.sv
// qualifies the low-supply indication over oscillator ticks
// assumes the comparator output is asynchronous to clock_i
`timescale 1ns/10ps
module wdrc_qual
   import wdrc_pkg::*;
#(
   parameter int unsigned QUAL_CYC = WDRC_BROWNOUT_QUAL_CYC
)
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic low_supply_i,
   wdrc_if.qual bus
);
   logic [1:0] sync_q, sync_d;
   logic [WDRC_DLY_W-1:0] cnt_q, cnt_d;
   logic hit_q, hit_d;

   always_comb begin
      sync_d = {sync_q[0], low_supply_i};
      cnt_d = cnt_q;
      hit_d = 1'b0;
      // a dip that ends before the count expires is forgotten
      // the comparator is ignored in sleep and idle
      if (!sync_q[1] || bus.low_power) begin
         cnt_d = '0;
      end else if (bus.tick) begin
         if (cnt_q >= WDRC_DLY_W'(QUAL_CYC)) begin
            hit_d = 1'b1;
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_q <= 2'h0;
         cnt_q <= '0;
         hit_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         cnt_q <= cnt_d;
         hit_q <= hit_d;
      end
   end

   assign bus.brownout_hit = hit_q;
endmodule

// File: design/wdrc_top.sv
// watchdog and reset-source control with an avalon-mm register slave
// assumes cpu strobes for clear and halt are one-cycle pulses on clock_i
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps

// Overview of operation
// - watchdog count advances only on low-speed oscillator edges
// - timeout select picks overflow at 2^8 up to 2^18 oscillator cycles
// - either valid enable key keeps the watchdog running normally
// - any other key resets the device after a delay, sets soft flag
// - power-on loads the valid key, so watchdog runs from power-up
// - soft reset flag starts 0, set by key reset, cleared by software
// - overflow in normal mode resets the device and sets timeout flag
// - overflow in sleep or idle sets timeout, clears only pc and stack
// - key reset, watchdog clear or halt all clear the count
// - brownout reset only after low supply outlasts qualification time
// - brownout reset disabled in sleep and idle modes
// - brownout flag bit 2 set by brownout reset, cleared by software
// - reset flag bits 7 to 3 and bit 1 read as zero
// - writing 55h to flash control one resets the whole device
// - power-on zeroes pc and sets all port registers high
// - halt sets the power-down flag and clears the timeout flag
// - power-up and watchdog clear both clear the power-down flag
// - power-on clears both flags; brownout leaves them unchanged
module wdrc_top
   import wdrc_pkg::*;
#(
   parameter int unsigned SOFT_DLY_CYC = WDRC_SOFT_DLY_CYC,
   parameter int unsigned QUAL_CYC = WDRC_BROWNOUT_QUAL_CYC
)
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic low_speed_osc_i,
   input wire logic low_supply_i,
   input wire logic watchdog_clear_instr_i,
   input wire logic halt_instr_i,
   input wire logic low_power_mode_i,
   output logic device_reset_o,
   output logic pc_sp_clear_o,
   output logic port_preset_o,
   output logic timeout_status_flag_o,
   output logic powerdown_flag_o
);
   wdrc_if link ();

   logic [7:0] wdt_ctrl_q, wdt_ctrl_d;
   logic soft_flag_q, soft_flag_d;
   logic brown_flag_q, brown_flag_d;
   logic to_q, to_d;
   logic pdf_q, pdf_d;
   wdrc_state_t state_q, state_d;
   logic [WDRC_DLY_W-1:0] dly_q, dly_d;
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic full_rst_q, full_rst_d;
   logic pcsp_q, pcsp_d;
   logic por_q, por_d;
   logic wr_take, rd_take;
   logic ovf_normal, ovf_sleep, flash_rst, brown_rst, soft_rst;

   wdrc_counter u_counter (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .low_speed_osc_i(low_speed_osc_i),
      .bus(link.ctr)
   );

   wdrc_qual #(.QUAL_CYC(QUAL_CYC)) u_qual (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .low_supply_i(low_supply_i),
      .bus(link.qual)
   );

   // one wait cycle, then the access completes at the edge after
   assign wr_take = avs_write_i & ack_q;
   assign rd_take = avs_read_i & ack_q;
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;

   assign ovf_normal = link.overflow & ~low_power_mode_i;
   assign ovf_sleep = link.overflow & low_power_mode_i;
   assign flash_rst = wr_take & avs_byteenable_i[0]
                      & (avs_address_i == WDRC_OFS_FLASH_CTRL_ONE)
                      & (avs_writedata_i[7:0] == WDRC_FLASH_RESET_VAL);
   assign brown_rst = link.brownout_hit & ~low_power_mode_i;
   assign soft_rst = (state_q == WDRC_ST_DELAY) && link.tick
                     && (dly_q >= WDRC_DLY_W'(SOFT_DLY_CYC));

   assign link.sel = wdt_ctrl_q[2:0];
   assign link.low_power = low_power_mode_i;
   // the count restarts on every clear source and on any full reset
   assign link.clear = watchdog_clear_instr_i | halt_instr_i
                       | (state_q == WDRC_ST_DELAY) | full_rst_q;

   always_comb begin
      state_d = state_q;
      dly_d = dly_q;
      case (state_q)
         WDRC_ST_RUN: begin
            dly_d = '0;
            // a bad key from a write or from corruption arms the delay
            // not in a reset cycle: the key is reloaded at its end, else resets chain
            if (!wdrc_key_ok(wdt_ctrl_q[7:3]) && !full_rst_q) begin
               state_d = WDRC_ST_DELAY;
            end
         end
         WDRC_ST_DELAY: begin
            // any other full reset cancels the pending one
            if (soft_rst || full_rst_q) begin
               state_d = WDRC_ST_RUN;
            end else if (link.tick) begin
               dly_d = dly_q + 1'b1;
            end
         end
         default: begin
            state_d = WDRC_ST_RUN;
         end
      endcase
   end

   always_comb begin
      wdt_ctrl_d = wdt_ctrl_q;
      soft_flag_d = soft_flag_q;
      brown_flag_d = brown_flag_q;
      to_d = to_q;
      pdf_d = pdf_q;
      if (wr_take && avs_byteenable_i[0]) begin
         if (avs_address_i == WDRC_OFS_WDT_CTRL) begin
            wdt_ctrl_d = avs_writedata_i[7:0];
         end
         if (avs_address_i == WDRC_OFS_RST_FLAGS) begin
            soft_flag_d = avs_writedata_i[WDRC_SOFT_FLAG_BIT];
            brown_flag_d = avs_writedata_i[WDRC_BROWNOUT_FLAG_BIT];
         end
      end
      // a full reset restores the valid key, otherwise it would retrigger forever
      if (full_rst_q) begin
         wdt_ctrl_d = WDRC_WDT_CTRL_RST;
      end
      if (watchdog_clear_instr_i) begin
         pdf_d = 1'b0;
      end
      if (halt_instr_i) begin
         pdf_d = 1'b1;
         to_d = 1'b0;
      end
      // hardware sets are applied last so they win over software clears
      if (soft_rst) begin
         soft_flag_d = 1'b1;
      end
      if (brown_rst) begin
         brown_flag_d = 1'b1;
      end
      // brownout touches neither status flag
      if (link.overflow) begin
         to_d = 1'b1;
      end
   end

   always_comb begin
      ack_d = (avs_read_i | avs_write_i) & ~ack_q;
      rdata_d = rdata_q;
      if (avs_read_i && !ack_q) begin
         case (avs_address_i)
            WDRC_OFS_WDT_CTRL: rdata_d = {24'h0, wdt_ctrl_q};
            // unimplemented flag bits stay zero
            WDRC_OFS_RST_FLAGS: rdata_d = {29'h0, brown_flag_q, 1'b0, soft_flag_q};
            WDRC_OFS_STATUS: rdata_d = {30'h0, pdf_q, to_q};
            default: rdata_d = 32'h0;
         endcase
      end
      full_rst_d = ovf_normal | flash_rst | brown_rst | soft_rst;
      pcsp_d = ovf_sleep | por_q;
      por_d = 1'b0;
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdt_ctrl_q <= WDRC_WDT_CTRL_RST;
         soft_flag_q <= 1'b0;
         brown_flag_q <= WDRC_BROWNOUT_FLAG_RST;
         to_q <= 1'b0;
         pdf_q <= 1'b0;
         state_q <= WDRC_ST_RUN;
         dly_q <= '0;
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
         full_rst_q <= 1'b0;
         pcsp_q <= 1'b1;
         por_q <= 1'b1;
      end else begin
         wdt_ctrl_q <= wdt_ctrl_d;
         soft_flag_q <= soft_flag_d;
         brown_flag_q <= brown_flag_d;
         to_q <= to_d;
         pdf_q <= pdf_d;
         state_q <= state_d;
         dly_q <= dly_d;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         full_rst_q <= full_rst_d;
         pcsp_q <= pcsp_d;
         por_q <= por_d;
      end
   end

   assign avs_readdata_o = rdata_q;
   assign device_reset_o = full_rst_q;
   assign pc_sp_clear_o = pcsp_q;
   assign port_preset_o = por_q;
   assign timeout_status_flag_o = to_q;
   assign powerdown_flag_o = pdf_q;
endmodule
